//--- gmm_top.v
`timescale 1ns/1ps
`include "gmm_regs.vh"
module gmm_top #(
  parameter MS_CYCLES = `GMM_MS_NS / `GMM_CLK_NS,
  parameter FW = 24
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Supplies and host pins
  input wire main_ok,
  input wire backup_ok,
  input wire host_wake_enable,
  input wire uart_rx,
  // Navigation engine
  input wire acq_done,
  input wire fix_valid,
  // Power domains and engine control
  output reg rf_power_en_reg,
  output reg ref_osc_en_reg,
  output reg search_en_reg,
  output reg nmea_en_reg,
  output reg hot_start_reg,
  output reg orbit_pred_en_reg,
  output reg [3:0] mode_reg,
  // Power cut, open drain
  output reg power_cut_o_reg,
  output reg power_cut_oe_reg,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam M_OFF = 4'h0;
  localparam M_ACQ = 4'h1;
  localparam M_TRACK = 4'h2;
  localparam M_STBY = 4'h3;
  localparam M_BKUP = 4'h4;
  localparam M_PON = 4'h5;
  localparam M_POFF = 4'h6;
  localparam M_ADAPT = 4'h7;
  localparam M_FIT = 4'h8;

  // Two-flop synchronisers for pin inputs
  reg [3:0] s1_reg;
  reg [3:0] s2_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Supplies read as absent until sampled, so no false power-up
      s1_reg <= 4'h1;
      s2_reg <= 4'h1;
    end else begin
      s1_reg <= {main_ok, backup_ok, host_wake_enable, uart_rx};
      s2_reg <= s1_reg;
    end
  end
  wire main_s = s2_reg[3];
  wire backup_s = s2_reg[2];
  wire wake_s = s2_reg[1];
  wire rx_s = s2_reg[0];

  reg [31:0] cfg_reg;
  reg [15:0] bit_cycles_reg;
  reg rx_en_reg;
  wire [7:0] rx_data;
  wire rx_valid;
  wire cmd_valid;
  wire [FW-1:0] f0;
  wire [FW-1:0] f1;
  wire [FW-1:0] f2;
  wire [FW-1:0] f3;
  wire [FW-1:0] f4;
  wire [FW-1:0] f5;

  // Frame is fixed 8N1
  gmm_uart_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .en(rx_en_reg),
    .bit_cycles(bit_cycles_reg),
    .rx(rx_s),
    .data(rx_data),
    .valid(rx_valid)
  );

  // Type, argument, run, sleep, retry run, retry sleep
  gmm_cmd_parse #(.FW(FW)) u_parse (
    .clk(clk),
    .rst_n(rst_n),
    .ch(rx_data),
    .ch_valid(rx_valid),
    .cmd_valid(cmd_valid),
    .f0(f0),
    .f1(f1),
    .f2(f2),
    .f3(f3),
    .f4(f4),
    .f5(f5)
  );

  // Serial rate table
  function [15:0] bit_div;
    input [2:0] sel;
    integer r;
    integer q;
    begin
      case (sel)
        3'h0: r = `GMM_BAUD_4800;
        3'h1: r = `GMM_BAUD_9600;
        3'h2: r = `GMM_BAUD_14400;
        3'h3: r = `GMM_BAUD_19200;
        3'h4: r = `GMM_BAUD_38400;
        3'h5: r = `GMM_BAUD_57600;
        default: r = `GMM_BAUD_115200;
      endcase
      q = (`GMM_CLK_HZ / r) - 1;
      bit_div = q[15:0];
    end
  endfunction

  // Command decode
  wire is_stby = cmd_valid && f0 == `GMM_CMD_STANDBY &&
    f1 == `GMM_STANDBY_ARG;
  wire is_per = cmd_valid && f0 == `GMM_CMD_PERIODIC;
  wire is_fit = cmd_valid && f0 == `GMM_CMD_FITNESS;
  wire full_on = mode_reg == M_ACQ || mode_reg == M_TRACK;

  // Periodic timing state
  reg [31:0] pre_reg;
  reg [FW-1:0] tmr_reg;
  reg [FW-1:0] run_reg;
  reg [FW-1:0] sleep_reg;
  reg [FW-1:0] run2_reg;
  reg [FW-1:0] sleep2_reg;
  reg per_bkup_reg;
  reg retry_reg;
  reg got_fix_reg;
  reg cut_reg;
  wire ms_tick = pre_reg == MS_CYCLES - 1;
  wire tmr_done = tmr_reg == {FW{1'b0}};
  reg [3:0] mode_next;

  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      M_OFF: begin
        if (main_s && backup_s) begin
          mode_next = M_ACQ;
        end
      end
      M_ACQ, M_TRACK: begin
        if (!main_s) begin
          mode_next = M_BKUP;
        end else if (is_stby) begin
          mode_next = M_STBY;
        end else if (is_per && f1 == `GMM_PER_FOREVER && !wake_s) begin
          mode_next = M_BKUP;
        end else if (is_per && (f1 == `GMM_PER_BACKUP ||
            f1 == `GMM_PER_STANDBY)) begin
          mode_next = M_PON;
        end else if (is_per && (f1 == `GMM_PER_ADAPT_S ||
            f1 == `GMM_PER_ADAPT_B)) begin
          mode_next = M_ADAPT;
        end else if (is_fit && f1 == 1) begin
          mode_next = M_FIT;
        end else if (mode_reg == M_ACQ && acq_done) begin
          mode_next = M_TRACK;
        end
      end
      M_STBY: begin
        if (!main_s) begin
          mode_next = M_BKUP;
        end else if (rx_valid) begin
          mode_next = M_ACQ;
        end
      end
      M_BKUP: begin
        // Forced backup leaves only by the wake line
        if (main_s && (wake_s || !cut_reg)) begin
          mode_next = M_ACQ;
        end
      end
      M_PON: begin
        if (is_per && f1 == `GMM_PER_EXIT) begin
          mode_next = M_ACQ;
        end else if (ms_tick && tmr_done) begin
          mode_next = M_POFF;
        end
      end
      M_POFF: begin
        if (is_per && f1 == `GMM_PER_EXIT && !per_bkup_reg) begin
          mode_next = M_ACQ;
        end else if (ms_tick && tmr_done) begin
          mode_next = M_PON;
        end
      end
      M_ADAPT: begin
        if (is_per && f1 == `GMM_PER_EXIT) begin
          mode_next = M_ACQ;
        end
      end
      M_FIT: begin
        if (is_fit && f1 == 0) begin
          mode_next = M_ACQ;
        end
      end
      default: mode_next = M_OFF;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= M_OFF;
      pre_reg <= 32'h00000000;
      tmr_reg <= {FW{1'b0}};
      run_reg <= {FW{1'b0}};
      sleep_reg <= {FW{1'b0}};
      run2_reg <= {FW{1'b0}};
      sleep2_reg <= {FW{1'b0}};
      per_bkup_reg <= 1'b0;
      retry_reg <= 1'b0;
      got_fix_reg <= 1'b0;
      cut_reg <= 1'b0;
      hot_start_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      hot_start_reg <= 1'b0;
      pre_reg <= ms_tick ? 32'h00000000 : pre_reg + 32'h00000001;
      if (ms_tick && !tmr_done) begin
        tmr_reg <= tmr_reg - {{(FW-1){1'b0}}, 1'b1};
      end
      if (mode_reg == M_PON && fix_valid) begin
        got_fix_reg <= 1'b1;
      end
      if (full_on && mode_next == M_PON) begin
        per_bkup_reg <= f1 == `GMM_PER_BACKUP;
        run_reg <= f2;
        sleep_reg <= f3;
        run2_reg <= f4;
        sleep2_reg <= f5;
        retry_reg <= 1'b0;
        got_fix_reg <= 1'b0;
        tmr_reg <= f2;
      end
      if (mode_reg == M_PON && mode_next == M_POFF) begin
        // No fix in the on window: retry periods
        retry_reg <= !(got_fix_reg || fix_valid);
        tmr_reg <= (got_fix_reg || fix_valid) ? sleep_reg : sleep2_reg;
      end
      if (mode_reg == M_POFF && mode_next == M_PON) begin
        got_fix_reg <= 1'b0;
        tmr_reg <= retry_reg ? run2_reg : run_reg;
      end
      if (full_on && mode_next == M_BKUP) begin
        cut_reg <= main_s;
      end else if (mode_next != M_BKUP) begin
        cut_reg <= 1'b0;
      end
      // Retained aiding data gives a hot restart
      if ((mode_reg == M_STBY || mode_reg == M_BKUP) &&
          mode_next == M_ACQ) begin
        hot_start_reg <= 1'b1;
      end
    end
  end

  // Mode-dependent outputs, one cycle behind the mode
  wire active = full_on || mode_reg == M_PON || mode_reg == M_FIT ||
    mode_reg == M_ADAPT;
  wire bk_off = mode_reg == M_BKUP || (mode_reg == M_POFF && per_bkup_reg);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_power_en_reg <= 1'b0;
      ref_osc_en_reg <= 1'b0;
      search_en_reg <= 1'b0;
      nmea_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      power_cut_o_reg <= 1'b0;
      power_cut_oe_reg <= 1'b0;
      orbit_pred_en_reg <= 1'b0;
      bit_cycles_reg <= 16'h0000;
    end else begin
      rf_power_en_reg <= active;
      ref_osc_en_reg <= active;
      search_en_reg <= active;
      nmea_en_reg <= active;
      rx_en_reg <= mode_reg != M_OFF && !bk_off;
      // Only ever pulls low, never drives high
      power_cut_o_reg <= 1'b0;
      power_cut_oe_reg <= (mode_reg == M_BKUP && cut_reg) ||
        (mode_reg == M_POFF && per_bkup_reg);
      orbit_pred_en_reg <= cfg_reg[`GMM_CFG_ORBIT] &&
        cfg_reg[`GMM_CFG_RATE_MSB:`GMM_CFG_RATE_LSB] ==
        `GMM_RATE_MIN;
      bit_cycles_reg <= bit_div(cfg_reg[`GMM_CFG_BAUD_MSB:
        `GMM_CFG_BAUD_LSB]);
    end
  end

  // AXI4-Lite write: address and data in either order
  reg aw_have_reg;
  reg w_have_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [31:0] wmerge;
  integer i;
  always @* begin
    wmerge = cfg_reg;
    for (i = 0; i < 4; i = i + 1) begin
      if (w_strb_reg[i]) begin
        wmerge[i*8 +: 8] = w_data_reg[i*8 +: 8];
      end
    end
  end
  wire [3:0] new_rate = wmerge[`GMM_CFG_RATE_MSB:`GMM_CFG_RATE_LSB];
  wire [2:0] new_baud = wmerge[`GMM_CFG_BAUD_MSB:`GMM_CFG_BAUD_LSB];
  wire do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GMM_RESP_OKAY;
      cfg_reg <= `GMM_CFG_RST;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (mode_reg == M_OFF && mode_next == M_ACQ) begin
        cfg_reg <= `GMM_CFG_RST;
      end else if (do_wr && aw_addr_reg == `GMM_CFG_OFS) begin
        // Out-of-range rates keep the old value
        cfg_reg <= {wmerge[31:8],
          (new_rate < `GMM_RATE_MIN || new_rate > `GMM_RATE_MAX) ?
          cfg_reg[`GMM_CFG_RATE_MSB:`GMM_CFG_RATE_LSB] : new_rate,
          wmerge[3],
          (new_baud > `GMM_BAUD_SEL_MAX) ?
          cfg_reg[`GMM_CFG_BAUD_MSB:`GMM_CFG_BAUD_LSB] : new_baud};
      end
      if (do_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg == `GMM_CFG_OFS) ?
          `GMM_RESP_OKAY : `GMM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read
  reg [FW-1:0] last_cmd_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GMM_RESP_OKAY;
      last_cmd_reg <= {FW{1'b0}};
    end else begin
      if (cmd_valid) begin
        last_cmd_reg <= f0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `GMM_RESP_OKAY;
        case (s_axi_araddr)
          `GMM_CFG_OFS: s_axi_rdata <= cfg_reg;
          `GMM_STAT_OFS: s_axi_rdata <= {22'h000000, cut_reg,
            per_bkup_reg, retry_reg, got_fix_reg, active, bk_off,
            mode_reg};
          `GMM_RUN_OFS: s_axi_rdata <= {{(32-FW){1'b0}}, tmr_reg};
          `GMM_CMD_OFS: s_axi_rdata <= {{(32-FW){1'b0}}, last_cmd_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `GMM_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- gmm_regs.vh
`ifndef GMM_REGS_VH
`define GMM_REGS_VH

// Register byte offsets
`define GMM_CFG_OFS 8'h00
`define GMM_STAT_OFS 8'h04
`define GMM_RUN_OFS 8'h08
`define GMM_CMD_OFS 8'h0C

// Configuration fields
`define GMM_CFG_BAUD_LSB 0
`define GMM_CFG_BAUD_MSB 2
`define GMM_CFG_RATE_LSB 4
`define GMM_CFG_RATE_MSB 7
`define GMM_CFG_NMEA_LSB 8
`define GMM_CFG_NMEA_MSB 13
`define GMM_CFG_SBAS 16
`define GMM_CFG_JAM 17
`define GMM_CFG_LOG 18
`define GMM_CFG_ORBIT 19
`define GMM_CFG_RST 32'h000B3F11
`define GMM_BAUD_SEL_MAX 3'h6
`define GMM_RATE_MIN 4'h1
`define GMM_RATE_MAX 4'hA

// Serial rates, bits per second
`define GMM_BAUD_4800 4800
`define GMM_BAUD_9600 9600
`define GMM_BAUD_14400 14400
`define GMM_BAUD_19200 19200
`define GMM_BAUD_38400 38400
`define GMM_BAUD_57600 57600
`define GMM_BAUD_115200 115200

// Timing
`define GMM_CLK_HZ 25000000
`define GMM_CLK_NS 40
`define GMM_MS_NS 1000000

// Command numbers and arguments
`define GMM_CMD_STANDBY 161
`define GMM_CMD_PERIODIC 225
`define GMM_CMD_FITNESS 262
`define GMM_STANDBY_ARG 0
`define GMM_PER_EXIT 0
`define GMM_PER_BACKUP 1
`define GMM_PER_STANDBY 2
`define GMM_PER_FOREVER 4
`define GMM_PER_ADAPT_S 8
`define GMM_PER_ADAPT_B 9

// Axi responses
`define GMM_RESP_OKAY 2'h0
`define GMM_RESP_SLVERR 2'h2

`endif

//--- gmm_uart_rx.v
`timescale 1ns/1ps
module gmm_uart_rx (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire en,
  input wire [15:0] bit_cycles,
  // Line, already synchronised
  input wire rx,
  // Received byte
  output reg [7:0] data,
  output reg valid
);
  reg [1:0] st_reg;
  reg [15:0] cnt_reg;
  reg [2:0] bit_reg;
  localparam S_IDLE = 2'h0;
  localparam S_START = 2'h1;
  localparam S_DATA = 2'h2;
  localparam S_STOP = 2'h3;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      data <= 8'h00;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!en) begin
        st_reg <= S_IDLE;
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end else begin
        case (st_reg)
          S_IDLE: begin
            if (!rx) begin
              st_reg <= S_START;
              cnt_reg <= {1'b0, bit_cycles[15:1]};
            end
          end
          S_START: begin
            // Glitch shorter than half a bit is dropped
            st_reg <= rx ? S_IDLE : S_DATA;
            cnt_reg <= bit_cycles;
            bit_reg <= 3'h0;
          end
          S_DATA: begin
            data <= {rx, data[7:1]};
            cnt_reg <= bit_cycles;
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              st_reg <= S_STOP;
            end
          end
          S_STOP: begin
            st_reg <= S_IDLE;
            valid <= rx;
          end
          default: st_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule

//--- gmm_cmd_parse.v
`timescale 1ns/1ps
module gmm_cmd_parse #(
  parameter FW = 24
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Incoming characters
  input wire [7:0] ch,
  input wire ch_valid,
  // Decoded sentence
  output reg cmd_valid,
  output reg [FW-1:0] f0,
  output reg [FW-1:0] f1,
  output reg [FW-1:0] f2,
  output reg [FW-1:0] f3,
  output reg [FW-1:0] f4,
  output reg [FW-1:0] f5
);
  reg [2:0] st_reg;
  reg [7:0] sum_reg;
  reg [7:0] rx_sum_reg;
  reg [FW-1:0] acc_reg;
  reg [2:0] idx_reg;
  reg [FW-1:0] fld [0:5];
  wire is_dig = (ch >= 8'h30) && (ch <= 8'h39);
  wire [3:0] hexv = is_dig ? ch[3:0] : ch[3:0] + 4'h9;
  localparam P_IDLE = 3'h0;
  localparam P_BODY = 3'h1;
  localparam P_HEX1 = 3'h2;
  localparam P_HEX2 = 3'h3;
  localparam P_CR = 3'h4;
  localparam P_LF = 3'h5;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= P_IDLE;
      sum_reg <= 8'h00;
      rx_sum_reg <= 8'h00;
      acc_reg <= {FW{1'b0}};
      idx_reg <= 3'h0;
      cmd_valid <= 1'b0;
      f0 <= {FW{1'b0}};
      f1 <= {FW{1'b0}};
      f2 <= {FW{1'b0}};
      f3 <= {FW{1'b0}};
      f4 <= {FW{1'b0}};
      f5 <= {FW{1'b0}};
    end else begin
      cmd_valid <= 1'b0;
      if (ch_valid) begin
        if (ch == 8'h24) begin
          st_reg <= P_BODY;
          sum_reg <= 8'h00;
          acc_reg <= {FW{1'b0}};
          idx_reg <= 3'h0;
        end else begin
          case (st_reg)
            P_BODY: begin
              if (ch == 8'h2A) begin
                st_reg <= P_HEX1;
              end else begin
                sum_reg <= sum_reg ^ ch;
              end
              if (ch == 8'h2C || ch == 8'h2A) begin
                if (idx_reg <= 3'h5) begin
                  fld[idx_reg] <= acc_reg;
                end
                idx_reg <= idx_reg + 3'h1;
                acc_reg <= {FW{1'b0}};
              end else if (is_dig) begin
                acc_reg <= acc_reg * 4'hA + {{(FW-4){1'b0}}, ch[3:0]};
              end
            end
            P_HEX1: begin
              rx_sum_reg[7:4] <= hexv;
              st_reg <= P_HEX2;
            end
            P_HEX2: begin
              rx_sum_reg[3:0] <= hexv;
              st_reg <= P_CR;
            end
            P_CR: st_reg <= (ch == 8'h0D) ? P_LF : P_IDLE;
            P_LF: begin
              st_reg <= P_IDLE;
              // Bad checksum drops the sentence
              if (ch == 8'h0A && rx_sum_reg == sum_reg) begin
                cmd_valid <= 1'b1;
                f0 <= fld[0];
                f1 <= (idx_reg > 3'h1) ? fld[1] : {FW{1'b0}};
                f2 <= (idx_reg > 3'h2) ? fld[2] : {FW{1'b0}};
                f3 <= (idx_reg > 3'h3) ? fld[3] : {FW{1'b0}};
                f4 <= (idx_reg > 3'h4) ? fld[4] : {FW{1'b0}};
                f5 <= (idx_reg > 3'h5) ? fld[5] : {FW{1'b0}};
              end
            end
            default: st_reg <= P_IDLE;
          endcase
        end
      end
    end
  end
endmodule

//--- gmm_monitor.sv
`timescale 1ns/1ps
module gmm_monitor (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Pins
  input wire main_ok,
  input wire backup_ok,
  input wire acq_done,
  // Outputs
  input wire [3:0] mode_reg,
  input wire rf_power_en_reg,
  input wire ref_osc_en_reg,
  input wire hot_start_reg,
  input wire power_cut_o_reg,
  input wire power_cut_oe_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Derived outputs lag mode by one cycle
  sequence stby_held;
    mode_reg == 4'h3 ##1 mode_reg == 4'h3;
  endsequence
  sequence stby_left;
    mode_reg == 4'h3 ##1 mode_reg != 4'h3;
  endsequence
  AST_POWER_UP: assert property (
    mode_reg == 4'h0 && main_ok && backup_ok |-> ##[1:4] mode_reg == 4'h1)
    else $error("no full on");
  AST_ACQ_TRACK: assert property (
    mode_reg == 4'h1 && acq_done |-> ##[1:3] mode_reg == 4'h2)
    else $error("no tracking");
  AST_STBY_RF: assert property (
    stby_held |-> !rf_power_en_reg && !ref_osc_en_reg)
    else $error("rf on in standby");
  AST_STBY_EXIT: assert property (
    stby_left |-> mode_reg == 4'h1 || mode_reg == 4'h4)
    else $error("bad standby exit");
  AST_HOT: assert property (
    stby_left ##0 mode_reg == 4'h1 |-> ##[0:2] hot_start_reg)
    else $error("no hot start");
  AST_ENTRY: assert property (
    $changed(mode_reg) && mode_reg inside {4'h3, 4'h7, 4'h8}
    |-> $past(mode_reg) inside {4'h1, 4'h2})
    else $error("entry not from full on");
  AST_CUT_OD: assert property (
    power_cut_oe_reg |-> !power_cut_o_reg) else $error("cut driven high");
  AST_CUT_BACKUP: assert property (
    power_cut_oe_reg |-> mode_reg inside {4'h4, 4'h6} ||
    $past(mode_reg) inside {4'h4, 4'h6}) else $error("cut outside backup");
endmodule
bind gmm_top gmm_monitor gmm_monitor_i (.clk(clk), .rst_n(rst_n),
  .main_ok(main_ok), .backup_ok(backup_ok), .acq_done(acq_done),
  .mode_reg(mode_reg), .rf_power_en_reg(rf_power_en_reg),
  .ref_osc_en_reg(ref_osc_en_reg), .hot_start_reg(hot_start_reg),
  .power_cut_o_reg(power_cut_o_reg), .power_cut_oe_reg(power_cut_oe_reg));

//--- gmm_host_model.sv
`timescale 1ns/1ps
module gmm_host_model #(
  parameter BIT_CYC = 217
) (
  // Clock and supply switch
  input wire clk,
  input wire supply_on,
  input wire power_cut_o_reg,
  input wire power_cut_oe_reg,
  // Host pins and supplies
  output logic uart_rx,
  output logic host_wake_enable,
  output wire main_ok,
  output wire backup_ok
);
  // Pull-up wins while released
  wire cut_line = power_cut_oe_reg ? power_cut_o_reg : 1'h1;
  // Switch gated by wake OR cut line
  assign main_ok = supply_on & (host_wake_enable | cut_line);
  assign backup_ok = 1'h1;
  initial begin
    uart_rx = 1'h1;
    host_wake_enable = 1'h0;
  end
  // Wake high is the only exit from forced backup
  task automatic set_wake(input logic v);
    @(posedge clk);
    host_wake_enable <= v;
  endtask
  // 8N1, lsb first, no flow control
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      uart_rx <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] d);
    return d < 4'hA ? 8'h30 + d : 8'h37 + d;
  endfunction
  // Fields in order, comma separated, hex checksum
  task automatic send_cmd(input string body, input logic bad);
    logic [7:0] cs;
    cs = 8'h00;
    for (int i = 0; i < body.len(); i++) cs ^= body[i];
    // Corrupt only when a test asks for it
    if (bad) cs = ~cs;
    send_byte(8'h24);
    for (int i = 0; i < body.len(); i++) send_byte(body[i]);
    send_byte(8'h2A);
    send_byte(hx(cs[7:4]));
    send_byte(hx(cs[3:0]));
    send_byte(8'h0D);
    send_byte(8'h0A);
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0, rst_n = 1'h0, supply_on = 1'h0;
  logic acq_done = 1'h0, fix_valid = 1'h0, hot_seen = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rsp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, main_ok, backup_ok, host_wake_enable, uart_rx;
  wire rf_power_en_reg, ref_osc_en_reg, search_en_reg, nmea_en_reg;
  wire hot_start_reg, orbit_pred_en_reg, power_cut_o_reg, power_cut_oe_reg;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] mode_reg;
  int miscompares = 0, total_checks = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (hot_start_reg) hot_seen <= 1'h1;
  gmm_top #(.MS_CYCLES(10)) gmm_top_i (.clk, .rst_n, .main_ok, .backup_ok,
    .host_wake_enable, .uart_rx, .acq_done, .fix_valid, .rf_power_en_reg,
    .ref_osc_en_reg, .search_en_reg, .nmea_en_reg, .hot_start_reg,
    .orbit_pred_en_reg, .mode_reg, .power_cut_o_reg, .power_cut_oe_reg,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  gmm_host_model host_i (.clk, .supply_on, .power_cut_o_reg,
    .power_cut_oe_reg, .uart_rx, .host_wake_enable, .main_ok, .backup_ok);
  task automatic chk(input string nm, input logic [31:0] ex, got);
    total_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Ready sampled mid-cycle, so release lands right after the edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    r = 1'h0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r) begin
      @(negedge clk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic wait_mode(input logic [3:0] m);
    for (int n = 0; n < 300 && mode_reg !== m; n++) @(negedge clk);
    chk("mode", {28'h0, m}, {28'h0, mode_reg});
  endtask
  task automatic t_power_up;
    repeat (10) @(negedge clk);
    chk("mode off", 32'h0, {28'h0, mode_reg});
    @(posedge clk);
    supply_on <= 1'h1;
    wait_mode(4'h1);
  endtask
  task automatic t_config;
    axi_rd(8'h00);
    chk("cfg reset", 32'h000B3F11, rd);
    chk("orbit on", 32'h1, {31'h0, orbit_pred_en_reg});
    axi_wr(8'h00, 32'h000B3F26);
    chk("cfg resp", 32'h0, {30'h0, rsp});
    repeat (3) @(negedge clk);
    chk("orbit off", 32'h0, {31'h0, orbit_pred_en_reg});
    axi_wr(8'h00, 32'h000B3FB6);
    axi_rd(8'h00);
    chk("rate kept", 32'h000B3F26, rd);
    axi_wr(8'h04, 32'h0);
    chk("ro resp", 32'h2, {30'h0, rsp});
    axi_rd(8'h10);
    chk("unmapped", 32'h2, {30'h0, rsp});
    axi_wr(8'h00, 32'h000B3F16);
    repeat (3) @(negedge clk);
    chk("orbit back", 32'h1, {31'h0, orbit_pred_en_reg});
  endtask
  task automatic t_track;
    @(posedge clk);
    acq_done <= 1'h1;
    @(posedge clk);
    acq_done <= 1'h0;
    wait_mode(4'h2);
  endtask
  task automatic t_standby;
    host_i.send_cmd("P161,0", 1'h0);
    wait_mode(4'h3);
    repeat (3) @(negedge clk);
    chk("domains", 32'h0, {28'h0, rf_power_en_reg, ref_osc_en_reg,
      search_en_reg, nmea_en_reg});
    host_i.send_byte(8'h55);
    wait_mode(4'h1);
    repeat (3) @(negedge clk);
    chk("hot start", 32'h1, {31'h0, hot_seen});
  endtask
  task automatic t_bad;
    t_track();
    host_i.send_cmd("P161,0", 1'h1);
    repeat (50) @(negedge clk);
    chk("bad sum", 32'h2, {28'h0, mode_reg});
  endtask
  task automatic t_backup;
    host_i.send_cmd("P225,4", 1'h0);
    wait_mode(4'h4);
    chk("cut", 32'h1, {31'h0, power_cut_oe_reg});
    chk("main off", 32'h0, {31'h0, main_ok});
    host_i.send_byte(8'h55);
    chk("uart off", 32'h4, {28'h0, mode_reg});
    host_i.set_wake(1'h1);
    wait_mode(4'h1);
    repeat (3) @(negedge clk);
    chk("released", 32'h0, {31'h0, power_cut_oe_reg});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    t_power_up();
    t_config();
    t_track();
    t_standby();
    t_bad();
    t_backup();
    final_report();
  end
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
